// *** cbbc_pkg.sv ***
package cbbc_pkg;
	// ****************************************
	// Configuration map
	// ****************************************
	localparam logic [7:0] OFF_BRIDGE_CTRL = 8'h3E;
	localparam logic [7:0] OFF_SUBSYS_VID = 8'h40;
	localparam logic [7:0] OFF_SYS_CTRL = 8'h80;
	localparam int NUM_SOCK = 2;
	localparam logic FUNC_SHARED = 1'h0;

	// ****************************************
	// Bridge control word
	// ****************************************
	localparam logic [15:0] BC_RESET = 16'h0340;
	// Bits kept per socket; 15..11 and 4 never stored
	localparam logic [15:0] BC_SOCK_MASK = 16'h07CF;
	localparam logic [15:0] BC_CARD_RESET_OUT_MASK = 16'h0040;
	localparam int BC_POST = 10;
	localparam int BC_PREF1 = 9;
	localparam int BC_PREF0 = 8;
	localparam int BC_IRQ_LEGACY = 7;
	localparam int BC_CARD_RESET_OUT = 6;
	localparam int BC_MABT = 5;
	localparam int BC_VGA = 3;
	localparam int BC_ISA = 2;
	localparam int BC_SERR = 1;
	localparam int BC_PERR = 0;
	localparam logic BC_MABT_RESET = 1'h0;

	// ****************************************
	// Subsystem vendor identification and lock
	// ****************************************
	localparam logic [15:0] SUBSYS_VID_RESET = 16'h0000;
	localparam int SYS_LOCK_BIT = 5;
	localparam logic SYS_LOCK_RESET = 1'h1;

	// ****************************************
	// ISA range filter: upper 768 bytes of each 1K block
	// ****************************************
	localparam logic [1:0] ISA_LOW_QUARTER = 2'h0;
endpackage

// *** cbbc_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module cbbc_regs (
	// Clock and resets
	input wire logic I_CLK_SYS,
	input wire logic I_RSTN,
	input wire logic I_PCI_BUS_RESET_N,
	input wire logic I_POWER_MGMT_EVENT_ENABLE,
	// Configuration access
	input wire logic I_CFG_WR,
	input wire logic I_CFG_RD,
	input wire logic I_CFG_FUNC,
	input wire logic [7:0] I_CFG_OFFSET,
	input wire logic [1:0] I_CFG_BE,
	input wire logic [15:0] I_CFG_WDATA,
	output logic [15:0] O_CFG_RDATA,
	output logic O_CFG_RVALID,
	// Serial memory load
	input wire logic I_EEPROM_VID_VALID,
	input wire logic [15:0] I_EEPROM_VID,
	// Card side events
	input wire logic [1:0] I_CARD_SYSTEM_ERROR,
	input wire logic [1:0] I_CARD_PARITY_DETECT,
	input wire logic [1:0] I_CARD_MASTER_ABORT,
	input wire logic I_SERR_ENABLE,
	input wire logic [15:0] I_IO_ADDR,
	// Controls and responses
	output logic [1:0] O_WRITE_POST_ENABLE,
	output logic [1:0] O_MEM_WINDOW1_PREFETCHABLE,
	output logic [1:0] O_MEM_WINDOW0_PREFETCHABLE,
	output logic [1:0] O_IRQ_ROUTE_LEGACY,
	output logic [1:0] O_CARD_RESET_OUT,
	output logic O_MASTER_ABORT_REPORT_MODE,
	output logic [1:0] O_VGA_FORWARD_ENABLE,
	output logic [1:0] O_IO_FORWARD_OK,
	output logic [1:0] O_CARD_PARITY_ERROR,
	output logic O_SERR_REQ,
	output logic O_TARGET_ABORT_REQ
);
	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [15:0] merge(input logic [15:0] old_v, input logic [15:0] new_v,
		input logic [1:0] be, input logic [15:0] mask);
		logic [15:0] lanes;
		lanes = {{8{be[1]}}, {8{be[0]}}} & mask;
		merge = (old_v & ~lanes) | (new_v & lanes);
	endfunction

	function automatic logic isa_pass(input logic [15:0] addr, input logic en);
		isa_pass = !en || (addr[9:8] == cbbc_pkg::ISA_LOW_QUARTER);
	endfunction

	// ****************************************
	// PCI reset pin synchroniser
	// ****************************************
	logic [2:0] pci_bus_reset_sync_r;
	logic pci_bus_reset_r, pci_bus_reset_nxt;
	always_comb begin
		pci_bus_reset_nxt = pci_bus_reset_r;
		if (pci_bus_reset_sync_r[1] == pci_bus_reset_sync_r[2]) begin
			pci_bus_reset_nxt = !pci_bus_reset_sync_r[2];
		end
	end
	always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
		if (!I_RSTN) begin
			pci_bus_reset_sync_r <= 3'h7;
			pci_bus_reset_r <= 1'h0;
		end else begin
			pci_bus_reset_sync_r <= {pci_bus_reset_sync_r[1:0], I_PCI_BUS_RESET_N};
			pci_bus_reset_r <= pci_bus_reset_nxt;
		end
	end

	// ****************************************
	// Register state
	// ****************************************
	logic [15:0] bc_r [cbbc_pkg::NUM_SOCK];
	logic [15:0] bc_nxt [cbbc_pkg::NUM_SOCK];
	logic [15:0] vid_r [cbbc_pkg::NUM_SOCK];
	logic [15:0] vid_nxt [cbbc_pkg::NUM_SOCK];
	logic mabt_r, mabt_nxt;
	logic lock_r, lock_nxt;
	logic wr_bc, wr_vid, wr_sys;

	assign wr_bc = I_CFG_WR && (I_CFG_OFFSET == cbbc_pkg::OFF_BRIDGE_CTRL);
	assign wr_vid = I_CFG_WR && (I_CFG_OFFSET == cbbc_pkg::OFF_SUBSYS_VID);
	assign wr_sys = I_CFG_WR && (I_CFG_OFFSET == cbbc_pkg::OFF_SYS_CTRL);

	always_comb begin
		mabt_nxt = mabt_r;
		lock_nxt = lock_r;
		// Shared bit takes writes from function 0 only
		if (wr_bc && I_CFG_FUNC == cbbc_pkg::FUNC_SHARED && I_CFG_BE[0]) begin
			mabt_nxt = I_CFG_WDATA[cbbc_pkg::BC_MABT];
		end
		if (pci_bus_reset_r) begin
			mabt_nxt = cbbc_pkg::BC_MABT_RESET;
		end
		if (wr_sys && I_CFG_BE[0]) begin
			lock_nxt = I_CFG_WDATA[cbbc_pkg::SYS_LOCK_BIT];
		end
		for (int s = 0; s < cbbc_pkg::NUM_SOCK; s++) begin
			bc_nxt[s] = bc_r[s];
			vid_nxt[s] = vid_r[s];
			if (wr_bc && I_CFG_FUNC == s[0]) begin
				bc_nxt[s] = merge(bc_r[s], I_CFG_WDATA, I_CFG_BE, cbbc_pkg::BC_SOCK_MASK);
			end
			if (pci_bus_reset_r) begin
				// Card reset bit survives PCI reset while POWER_MGMT_EVENT is armed
				bc_nxt[s] = (cbbc_pkg::BC_RESET & ~cbbc_pkg::BC_CARD_RESET_OUT_MASK) |
					((I_POWER_MGMT_EVENT_ENABLE ? bc_r[s] : cbbc_pkg::BC_RESET) &
					cbbc_pkg::BC_CARD_RESET_OUT_MASK);
			end
			if (wr_vid && I_CFG_FUNC == s[0] && !lock_r) begin
				vid_nxt[s] = merge(vid_r[s], I_CFG_WDATA, I_CFG_BE, 16'hFFFF);
			end
			// Serial memory load is not gated by the lock
			if (I_EEPROM_VID_VALID) begin
				vid_nxt[s] = I_EEPROM_VID;
			end
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
		if (!I_RSTN) begin
			for (int s = 0; s < cbbc_pkg::NUM_SOCK; s++) begin
				bc_r[s] <= cbbc_pkg::BC_RESET;
				vid_r[s] <= cbbc_pkg::SUBSYS_VID_RESET;
			end
			mabt_r <= cbbc_pkg::BC_MABT_RESET;
			lock_r <= cbbc_pkg::SYS_LOCK_RESET;
		end else begin
			bc_r <= bc_nxt;
			vid_r <= vid_nxt;
			mabt_r <= mabt_nxt;
			lock_r <= lock_nxt;
		end
	end

	// ****************************************
	// Read path and outputs
	// ****************************************
	logic [15:0] rdata_nxt;
	logic [1:0] card_reset_out_nxt, perr_nxt, fwd_nxt;
	logic serr_nxt, tabt_nxt;
	always_comb begin
		rdata_nxt = 16'h0000;
		unique case (I_CFG_OFFSET)
			cbbc_pkg::OFF_BRIDGE_CTRL: begin
				// Unstored bits 15..11 and 4 fall out as zero
				rdata_nxt = (bc_r[I_CFG_FUNC] & cbbc_pkg::BC_SOCK_MASK) |
					(16'(mabt_r) << cbbc_pkg::BC_MABT);
			end
			cbbc_pkg::OFF_SUBSYS_VID: begin
				rdata_nxt = vid_r[I_CFG_FUNC];
			end
			cbbc_pkg::OFF_SYS_CTRL: begin
				rdata_nxt = 16'(lock_r) << cbbc_pkg::SYS_LOCK_BIT;
			end
			default: begin
				rdata_nxt = 16'h0000;
			end
		endcase
		tabt_nxt = mabt_r && (|I_CARD_MASTER_ABORT);
		serr_nxt = (tabt_nxt && I_SERR_ENABLE);
		for (int s = 0; s < cbbc_pkg::NUM_SOCK; s++) begin
			card_reset_out_nxt[s] = bc_r[s][cbbc_pkg::BC_CARD_RESET_OUT] || pci_bus_reset_r;
			perr_nxt[s] = I_CARD_PARITY_DETECT[s] && bc_r[s][cbbc_pkg::BC_PERR];
			fwd_nxt[s] = isa_pass(I_IO_ADDR, bc_r[s][cbbc_pkg::BC_ISA]);
			serr_nxt = serr_nxt || (I_CARD_SYSTEM_ERROR[s] && bc_r[s][cbbc_pkg::BC_SERR]);
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
		if (!I_RSTN) begin
			O_CFG_RDATA <= 16'h0000;
			O_CFG_RVALID <= 1'h0;
			O_CARD_RESET_OUT <= 2'h3;
			O_CARD_PARITY_ERROR <= 2'h0;
			O_IO_FORWARD_OK <= 2'h3;
			O_SERR_REQ <= 1'h0;
			O_TARGET_ABORT_REQ <= 1'h0;
		end else begin
			O_CFG_RDATA <= I_CFG_RD ? rdata_nxt : O_CFG_RDATA;
			O_CFG_RVALID <= I_CFG_RD;
			O_CARD_RESET_OUT <= card_reset_out_nxt;
			O_CARD_PARITY_ERROR <= perr_nxt;
			O_IO_FORWARD_OK <= fwd_nxt;
			O_SERR_REQ <= serr_nxt;
			O_TARGET_ABORT_REQ <= tabt_nxt;
		end
	end

	// Plain control bits are the stored flops themselves
	always_comb begin
		for (int s = 0; s < cbbc_pkg::NUM_SOCK; s++) begin
			O_WRITE_POST_ENABLE[s] = bc_r[s][cbbc_pkg::BC_POST];
			O_MEM_WINDOW1_PREFETCHABLE[s] = bc_r[s][cbbc_pkg::BC_PREF1];
			O_MEM_WINDOW0_PREFETCHABLE[s] = bc_r[s][cbbc_pkg::BC_PREF0];
			O_IRQ_ROUTE_LEGACY[s] = bc_r[s][cbbc_pkg::BC_IRQ_LEGACY];
			O_VGA_FORWARD_ENABLE[s] = bc_r[s][cbbc_pkg::BC_VGA];
		end
		O_MASTER_ABORT_REPORT_MODE = mabt_r;
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_RSTN);
	logic rd_bc_r;
	always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
		if (!I_RSTN) begin
			rd_bc_r <= 1'h0;
		end else begin
			rd_bc_r <= I_CFG_RD && (I_CFG_OFFSET == cbbc_pkg::OFF_BRIDGE_CTRL);
		end
	end

	rsv_high_zero_a: assert property (rd_bc_r |-> O_CFG_RDATA[15:11] == 5'h00)
		else $error("reserved high bits read nonzero");
	rsv_bit4_zero_a: assert property (rd_bc_r |-> !O_CFG_RDATA[4])
		else $error("reserved bit 4 read nonzero");
	card_reset_out_pci_bus_reset_a: assert property (pci_bus_reset_r |=> O_CARD_RESET_OUT == 2'h3)
		else $error("card reset not passed through");
	card_reset_out_bit_a: assert property (!pci_bus_reset_r && !bc_r[0][cbbc_pkg::BC_CARD_RESET_OUT]
		|=> !O_CARD_RESET_OUT[0])
		else $error("card reset not following bit");
	card_reset_out_pme_a: assert property (pci_bus_reset_r && I_POWER_MGMT_EVENT_ENABLE
		|=> bc_r[1][cbbc_pkg::BC_CARD_RESET_OUT] == $past(bc_r[1][cbbc_pkg::BC_CARD_RESET_OUT]))
		else $error("card reset bit touched under POWER_MGMT_EVENT");
	pci_bus_reset_pref_a: assert property (pci_bus_reset_r |=> bc_r[0][cbbc_pkg::BC_PREF1] &&
		bc_r[0][cbbc_pkg::BC_PREF0])
		else $error("prefetch bits not reset");
	mabt_func1_a: assert property (!pci_bus_reset_r && !(wr_bc && I_CFG_FUNC == cbbc_pkg::FUNC_SHARED)
		|=> $stable(mabt_r))
		else $error("shared bit changed without function 0");
	vid_lock_a: assert property (lock_r && !I_EEPROM_VID_VALID |=> $stable(vid_r[0]))
		else $error("locked vendor id changed");
	vid_pci_bus_reset_a: assert property (pci_bus_reset_r && !wr_vid && !I_EEPROM_VID_VALID
		|=> $stable(vid_r[1]))
		else $error("vendor id cleared by PCI reset");
	perr_a: assert property (I_CARD_PARITY_DETECT[1] && bc_r[1][cbbc_pkg::BC_PERR]
		|=> O_CARD_PARITY_ERROR[1])
		else $error("parity error not reported");
	serr_a: assert property (I_CARD_SYSTEM_ERROR[0] && !bc_r[0][cbbc_pkg::BC_SERR] &&
		!I_CARD_SYSTEM_ERROR[1] && !(|I_CARD_MASTER_ABORT) |=> !O_SERR_REQ)
		else $error("system error forwarded while disabled");
	isa_a: assert property (bc_r[0][cbbc_pkg::BC_ISA] && I_IO_ADDR[9:8] != 2'h0
		|=> !O_IO_FORWARD_OK[0])
		else $error("upper ISA bytes forwarded");

	// ****************************************
	// Abort, load and storage checks
	// ****************************************
	// A master abort on socket 1 must raise the target abort request while abort reporting mode is set
	tabt_report_a: assert property (mabt_r && I_CARD_MASTER_ABORT[1] |=> O_TARGET_ABORT_REQ)
		else $error("master abort not reported");
	serr_gate_a: assert property (!I_SERR_ENABLE && !(|(I_CARD_SYSTEM_ERROR &
		{bc_r[1][cbbc_pkg::BC_SERR], bc_r[0][cbbc_pkg::BC_SERR]})) |=> !O_SERR_REQ)
		else $error("abort raised SERR while disabled");
	mabt_pci_bus_reset_a: assert property (pci_bus_reset_r |=> !mabt_r)
		else $error("abort mode not reset by PCI reset");
	card_reset_out_nopme_a: assert property (pci_bus_reset_r && !I_POWER_MGMT_EVENT_ENABLE
		|=> bc_r[0][cbbc_pkg::BC_CARD_RESET_OUT])
		else $error("card reset bit not reloaded");
	rd_valid_a: assert property (I_CFG_RD |=> O_CFG_RVALID)
		else $error("read not answered");
	vid_load_a: assert property (I_EEPROM_VID_VALID
		|=> vid_r[0] == $past(I_EEPROM_VID))
		else $error("serial load not taken");
	rsv_store_a: assert property ((bc_r[1] & ~cbbc_pkg::BC_SOCK_MASK) == 16'h0000)
		else $error("unstored bits held a value");

	bc_write_c: cover property (wr_bc ##1 I_CFG_RD ##1 O_CFG_RVALID);
	pci_bus_reset_pulse_c: cover property (pci_bus_reset_r ##[1:8] !pci_bus_reset_r);
	vid_unlocked_c: cover property (!lock_r && wr_vid);
	tabt_c: cover property (O_TARGET_ABORT_REQ && O_SERR_REQ);
	// Serial load must win over the lock
	load_locked_c: cover property (lock_r && I_EEPROM_VID_VALID);
endmodule
`default_nettype wire

// *** cbbc_card_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Card side event source
// ****************************************
module cbbc_card_model (
	// Clock
	input wire logic i_clk,
	// Requested system error, parity and abort levels
	input wire logic [5:0] i_ev,
	// Pins toward the bridge
	output logic [1:0] o_serr,
	output logic [1:0] o_par,
	output logic [1:0] o_abt
);
	// Falling edge launch keeps pins settled at the bridge's sampling edge
	always_ff @(negedge i_clk) begin
		{o_serr, o_par, o_abt} <= i_ev;
	end
endmodule
`default_nettype wire

// *** cardbus_bridge_control_regs_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module cardbus_bridge_control_regs_bench;
	logic clk, rstn, pci_bus_reset_n, power_mgmt_event, wr, rd, func, eev, rv, mabt, serr, tabt;
	logic [7:0] off;
	logic [15:0] wd, rdata, eid, ioa;
	logic [5:0] ev;
	logic [1:0] se, pe, ab, post, pf1, pf0, irq, card_reset_out, vga, iok, cpe, be;
	logic sen;
	int miscompares = 0;
	int checks_done = 0;
	// ****************************************
	// Clock, design and card side
	// ****************************************
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	cbbc_regs u_dut (
		.I_CLK_SYS(clk),
		.I_RSTN(rstn),
		.I_PCI_BUS_RESET_N(pci_bus_reset_n),
		.I_POWER_MGMT_EVENT_ENABLE(power_mgmt_event),
		.I_CFG_WR(wr),
		.I_CFG_RD(rd),
		.I_CFG_FUNC(func),
		.I_CFG_OFFSET(off),
		.I_CFG_BE(be),
		.I_CFG_WDATA(wd),
		.O_CFG_RDATA(rdata),
		.O_CFG_RVALID(rv),
		.I_EEPROM_VID_VALID(eev),
		.I_EEPROM_VID(eid),
		.I_CARD_SYSTEM_ERROR(se),
		.I_CARD_PARITY_DETECT(pe),
		.I_CARD_MASTER_ABORT(ab),
		.I_SERR_ENABLE(sen),
		.I_IO_ADDR(ioa),
		.O_WRITE_POST_ENABLE(post),
		.O_MEM_WINDOW1_PREFETCHABLE(pf1),
		.O_MEM_WINDOW0_PREFETCHABLE(pf0),
		.O_IRQ_ROUTE_LEGACY(irq),
		.O_CARD_RESET_OUT(card_reset_out),
		.O_MASTER_ABORT_REPORT_MODE(mabt),
		.O_VGA_FORWARD_ENABLE(vga),
		.O_IO_FORWARD_OK(iok),
		.O_CARD_PARITY_ERROR(cpe),
		.O_SERR_REQ(serr),
		.O_TARGET_ABORT_REQ(tabt)
	);
	cbbc_card_model u_card (.i_clk(clk), .i_ev(ev), .o_serr(se), .o_par(pe), .o_abt(ab));
	// ****************************************
	// Access tasks
	// ****************************************
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task cfg_wr(input logic f, input logic [7:0] o, input logic [15:0] d);
		@(negedge clk);
		{wr, func, off, wd} = {1'h1, f, o, d};
		@(negedge clk);
		wr = 0;
	endtask
	task cfg_rd(input logic f, input logic [7:0] o, input logic [15:0] exp);
		@(negedge clk);
		{rd, func, off} = {1'h1, f, o};
		@(negedge clk);
		rd = 0;
		chk({15'h0, rv}, 16'h0001);
		chk(rdata, exp);
	endtask
	// Internal reset follows the pin only after its synchroniser
	task pci_reset(input logic p);
		power_mgmt_event = p;
		pci_bus_reset_n = 0;
		repeat (8) @(negedge clk);
		chk({14'h0, card_reset_out}, 16'h0003);
		pci_bus_reset_n = 1;
		repeat (6) @(negedge clk);
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk);
		miscompares++;
		print_verdict;
	end
	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		{rstn, pci_bus_reset_n, power_mgmt_event, wr, rd, func, eev, off, wd, eid, ioa, ev} = 0;
		pci_bus_reset_n = 1;
		be = 2'h3;
		sen = 1;
		repeat (3) @(negedge clk);
		rstn = 1;
		cfg_rd(0, 8'h3E, 16'h0340);
		cfg_rd(1, 8'h3E, 16'h0340);
		cfg_rd(0, 8'h40, 16'h0000);
		cfg_rd(0, 8'h80, 16'h0020);
		chk({14'h0, card_reset_out}, 16'h0003);
		cfg_wr(0, 8'h3E, 16'hFFFF);
		cfg_rd(0, 8'h3E, 16'h07EF);
		cfg_wr(1, 8'h3E, 16'h0000);
		cfg_rd(1, 8'h3E, 16'h0020);
		chk({3'h0, post, pf1, pf0, irq, card_reset_out, vga, mabt}, 16'h0AAB);
		ioa = 16'h0300;
		ev = 6'h3D;
		repeat (3) @(negedge clk);
		chk({10'h0, iok, cpe, serr, tabt}, 16'h0027);
		ioa = 16'h00FF;
		ev = 6'h28;
		repeat (3) @(negedge clk);
		chk({10'h0, iok, cpe, serr, tabt}, 16'h0030);
		sen = 0;
		ev = 6'h01;
		repeat (3) @(negedge clk);
		chk({10'h0, iok, cpe, serr, tabt}, 16'h0031);
		sen = 1;
		ev = 0;
		be = 2'h2;
		cfg_wr(0, 8'h3E, 16'h0000);
		be = 2'h3;
		cfg_rd(0, 8'h3E, 16'h00EF);
		cfg_wr(0, 8'h3C, 16'hFFFF);
		cfg_rd(0, 8'h3C, 16'h0000);
		cfg_wr(0, 8'h40, 16'h1234);
		cfg_rd(0, 8'h40, 16'h0000);
		cfg_wr(0, 8'h80, 16'h0000);
		cfg_wr(0, 8'h40, 16'hABCD);
		cfg_rd(0, 8'h40, 16'hABCD);
		cfg_wr(0, 8'h80, 16'h0020);
		cfg_wr(0, 8'h40, 16'h5555);
		cfg_rd(0, 8'h40, 16'hABCD);
		cfg_wr(0, 8'h3E, 16'h0000);
		pci_reset(1);
		cfg_rd(0, 8'h3E, 16'h0300);
		cfg_rd(0, 8'h40, 16'hABCD);
		chk({14'h0, card_reset_out}, 16'h0000);
		pci_reset(0);
		cfg_rd(0, 8'h3E, 16'h0340);
		@(negedge clk);
		{eev, eid} = {1'h1, 16'h5A5A};
		@(negedge clk);
		eev = 0;
		cfg_rd(1, 8'h40, 16'h5A5A);
		rstn = 0;
		repeat (2) @(negedge clk);
		rstn = 1;
		cfg_rd(1, 8'h40, 16'h0000);
		print_verdict;
	end
endmodule
`default_nettype wire
